// File: pkg/cct_cfg.svh
// Constants of the 16-bit capture/compare timer: register offsets, reset values,
// clock select codes and prescaler masks. Included by the package and the design.
// Assumes a 20 MHz system clock and APB with 32-bit data, one register per word.
`ifndef CCT_CFG_SVH
`define CCT_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CCT_OFF_CTRL_ONE    6'h00
`define CCT_OFF_CTRL_TWO    6'h04
`define CCT_OFF_STATUS      6'h08
`define CCT_OFF_CNT_HI      6'h0C
`define CCT_OFF_CNT_LO      6'h10
`define CCT_OFF_SHD_HI      6'h14
`define CCT_OFF_SHD_LO      6'h18
`define CCT_OFF_CAP1_HI     6'h1C
`define CCT_OFF_CAP1_LO     6'h20
`define CCT_OFF_CAP2_HI     6'h24
`define CCT_OFF_CAP2_LO     6'h28
`define CCT_OFF_CMP1_HI     6'h2C
`define CCT_OFF_CMP1_LO     6'h30
`define CCT_OFF_CMP2_HI     6'h34
`define CCT_OFF_CMP2_LO     6'h38

// ****************************************************************
// Reset values and counter wrap value
// ****************************************************************
`define CCT_CNT_RESET       16'hFFFC
`define CCT_CMP_RESET       16'h8000
`define CCT_CNT_WRAP        16'hFFFF

// ****************************************************************
// Clock select codes and prescaler masks
// ****************************************************************
`define CCT_CS_DIV4         2'h0
`define CCT_CS_DIV8         2'h1
`define CCT_CS_DIV2         2'h2
`define CCT_CS_EXT          2'h3
`define CCT_MASK_DIV2       3'h1
`define CCT_MASK_DIV4       3'h3
`define CCT_MASK_DIV8       3'h7

`endif

// File: pkg/cct_pkg.sv
// Types of the 16-bit capture/compare timer.
// Assumes cct_cfg.svh is on the include path.
`include "cct_cfg.svh"

package cct_pkg;

    // ****************************************************************
    // Control register one (bit 7 down to bit 0)
    // ****************************************************************
    typedef struct packed {
        logic capture_irq_enable;
        logic compare_irq_enable;
        logic rollover_irq_enable;
        logic rsvd;
        logic compare_output_level2;
        logic compare_output_level1;
        logic capture_edge_select1;
        logic rsvd0;
    } cct_ctrl_one_s;

    // ****************************************************************
    // Control register two (bit 7 down to bit 0)
    // ****************************************************************
    typedef struct packed {
        logic       compare_output_enable1;
        logic       compare_output_enable2;
        logic       one_pulse_mode;
        logic       pwm_mode;
        logic [1:0] clock_select_field;
        logic       capture_edge_select2;
        logic       ext_clock_edge_select;
    } cct_ctrl_two_s;

    // ****************************************************************
    // Status register (bit 7 down to bit 0)
    // ****************************************************************
    typedef struct packed {
        logic       capture_flag1;
        logic       compare_flag1;
        logic       rollover_flag;
        logic       capture_flag2;
        logic       compare_flag2;
        logic [2:0] rsvd;
    } cct_status_s;

endpackage

// File: verilog/cct_timer.sv
// 16-bit free-running timer with two capture and two compare channels, APB slave.
// Assumes all pins are synchronous to clk_sys and the APB master follows the protocol.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`include "cct_cfg.svh"

module cct_timer (
    // System
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [5:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // CPU side
    input  wire logic        cpu_irq_mask,
    input  wire logic        halt_mode,
    output logic             timer_irq,
    // Timer pins
    input  wire logic        ext_clock_pin,
    input  wire logic [1:0]  capture_pin,
    output logic      [1:0]  compare_output_pin,
    output logic      [1:0]  compare_output_pin_oe
);

    // ****************************************************************
    // State
    // ****************************************************************
    cct_pkg::cct_ctrl_one_s ctrl_one_q, ctrl_one_d;
    cct_pkg::cct_ctrl_two_s ctrl_two_q, ctrl_two_d;
    cct_pkg::cct_status_s   status_q,   status_d;
    logic [15:0]            count_q,    count_d;
    logic [2:0]             presc_q,    presc_d;
    logic                   ext_prev_q, ext_prev_d;
    logic                   new_count_q, new_count_d;
    logic [7:0]             lo_buf_q [2];
    logic [7:0]             lo_buf_d [2];
    logic [1:0]             lo_pend_q,  lo_pend_d;
    logic [15:0]            cap_q [2];
    logic [15:0]            cap_d [2];
    logic [3:0]             cap_prev_q, cap_prev_d;
    logic [1:0]             cap_lock_q, cap_lock_d;
    logic [15:0]            cmp_q [2];
    logic [15:0]            cmp_d [2];
    logic [1:0]             cmp_lock_q, cmp_lock_d;
    logic [1:0]             pin_q,      pin_d;
    cct_pkg::cct_status_s   arm_q,      arm_d;
    logic [31:0]            rdata_q,    rdata_d;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
        edge_hit = rising ? (!prev && cur) : (prev && !cur);
    endfunction

    function automatic logic is_addr(input logic [5:0] a, input logic [5:0] off);
        is_addr = (a == off);
    endfunction

    // Bus phases; zero wait states so the access edge is the effect edge
    logic access;
    logic wr;
    logic rd;
    logic mapped;
    assign access  = psel && penable;
    assign wr      = access && pwrite;
    assign rd      = access && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata  = rdata_q;

    // Address decode
    always_comb begin
        case (paddr)
            `CCT_OFF_CTRL_ONE, `CCT_OFF_CTRL_TWO, `CCT_OFF_STATUS,
            `CCT_OFF_CNT_HI,   `CCT_OFF_CNT_LO,   `CCT_OFF_SHD_HI, `CCT_OFF_SHD_LO,
            `CCT_OFF_CAP1_HI,  `CCT_OFF_CAP1_LO,  `CCT_OFF_CAP2_HI, `CCT_OFF_CAP2_LO,
            `CCT_OFF_CMP1_HI,  `CCT_OFF_CMP1_LO,  `CCT_OFF_CMP2_HI, `CCT_OFF_CMP2_LO: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Timer tick from prescaler or external pin
    logic [2:0] presc_mask;
    logic       tick;
    always_comb begin
        case (ctrl_two_q.clock_select_field)
            `CCT_CS_DIV2: presc_mask = `CCT_MASK_DIV2;
            `CCT_CS_DIV8: presc_mask = `CCT_MASK_DIV8;
            default:      presc_mask = `CCT_MASK_DIV4;
        endcase
        if (halt_mode) begin
            tick = 1'b0;
        end else if (ctrl_two_q.clock_select_field == `CCT_CS_EXT) begin
            // Edge taken at the pin sample; the source keeps four system clocks apart
            tick = edge_hit(ext_prev_q, ext_clock_pin, ctrl_two_q.ext_clock_edge_select);
        end else begin
            tick = ((presc_q & presc_mask) == presc_mask);
        end
    end

    // Access strobes per register
    logic wr_cnt_lo;
    logic wr_shd_lo;
    logic [1:0] cap_hi_rd;
    logic [1:0] cap_lo_acc;
    logic [1:0] cmp_hi_wr;
    logic [1:0] cmp_lo_wr;
    logic [1:0] cmp_lo_acc;
    logic [1:0] cap_en;
    logic [1:0] cap_edge;
    logic [1:0] cmp_hit;
    always_comb begin
        wr_cnt_lo     = wr && is_addr(paddr, `CCT_OFF_CNT_LO);
        wr_shd_lo     = wr && is_addr(paddr, `CCT_OFF_SHD_LO);
        cap_hi_rd[0]  = rd && is_addr(paddr, `CCT_OFF_CAP1_HI);
        cap_hi_rd[1]  = rd && is_addr(paddr, `CCT_OFF_CAP2_HI);
        cap_lo_acc[0] = access && is_addr(paddr, `CCT_OFF_CAP1_LO);
        cap_lo_acc[1] = access && is_addr(paddr, `CCT_OFF_CAP2_LO);
        cmp_hi_wr[0]  = wr && is_addr(paddr, `CCT_OFF_CMP1_HI);
        cmp_hi_wr[1]  = wr && is_addr(paddr, `CCT_OFF_CMP2_HI);
        cmp_lo_wr[0]  = wr && is_addr(paddr, `CCT_OFF_CMP1_LO);
        cmp_lo_wr[1]  = wr && is_addr(paddr, `CCT_OFF_CMP2_LO);
        cmp_lo_acc[0] = access && is_addr(paddr, `CCT_OFF_CMP1_LO);
        cmp_lo_acc[1] = access && is_addr(paddr, `CCT_OFF_CMP2_LO);
        // Channel one is taken by the pulse modes
        cap_en[0] = !(ctrl_two_q.one_pulse_mode || ctrl_two_q.pwm_mode);
        cap_en[1] = 1'b1;
        // Pins are watched whatever their port direction
        cap_edge[0] = edge_hit(cap_prev_q[2], cap_prev_q[0], ctrl_one_q.capture_edge_select1);
        cap_edge[1] = edge_hit(cap_prev_q[3], cap_prev_q[1], ctrl_two_q.capture_edge_select2);
        // Compare once per new count so the flag marks the matching count
        for (int i = 0; i < 2; i++) begin
            cmp_hit[i] = new_count_q && !cmp_lock_q[i] && (count_q == cmp_q[i]);
        end
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb begin
        ctrl_one_d  = ctrl_one_q;
        ctrl_two_d  = ctrl_two_q;
        status_d    = status_q;
        count_d     = count_q;
        presc_d     = halt_mode ? presc_q : presc_q + 3'h1;
        ext_prev_d  = ext_clock_pin;
        new_count_d = tick;
        lo_buf_d    = lo_buf_q;
        lo_pend_d   = lo_pend_q;
        cap_d       = cap_q;
        cap_prev_d  = {cap_prev_q[1:0], capture_pin};
        cap_lock_d  = cap_lock_q;
        cmp_d       = cmp_q;
        cmp_lock_d  = cmp_lock_q;
        pin_d       = pin_q;
        arm_d       = arm_q;
        rdata_d     = rdata_q;

        // Counter advance and rollover
        if (tick) begin
            count_d = count_q + 16'h1;
            if (count_q == `CCT_CNT_WRAP) begin
                status_d.rollover_flag = 1'b1;
            end
        end
        if (wr_cnt_lo || wr_shd_lo) begin
            count_d = `CCT_CNT_RESET;
            presc_d = 3'h0;
        end

        // Read data prepared in setup phase; side effects at the access edge, except the count low-byte latch, taken at setup
        if (psel && !penable && !pwrite) begin
            rdata_d = 32'h0;
            case (paddr)
                `CCT_OFF_CTRL_ONE: rdata_d[7:0] = ctrl_one_q;
                `CCT_OFF_CTRL_TWO: rdata_d[7:0] = ctrl_two_q;
                `CCT_OFF_STATUS:   rdata_d[7:0] = status_q;
                `CCT_OFF_CNT_HI,
                `CCT_OFF_SHD_HI:   rdata_d[7:0] = count_q[15:8];
                `CCT_OFF_CNT_LO:   rdata_d[7:0] = lo_pend_q[0] ? lo_buf_q[0] : count_q[7:0];
                `CCT_OFF_SHD_LO:   rdata_d[7:0] = lo_pend_q[1] ? lo_buf_q[1] : count_q[7:0];
                `CCT_OFF_CAP1_HI:  rdata_d[7:0] = cap_q[0][15:8];
                `CCT_OFF_CAP1_LO:  rdata_d[7:0] = cap_q[0][7:0];
                `CCT_OFF_CAP2_HI:  rdata_d[7:0] = cap_q[1][15:8];
                `CCT_OFF_CAP2_LO:  rdata_d[7:0] = cap_q[1][7:0];
                `CCT_OFF_CMP1_HI:  rdata_d[7:0] = cmp_q[0][15:8];
                `CCT_OFF_CMP1_LO:  rdata_d[7:0] = cmp_q[0][7:0];
                `CCT_OFF_CMP2_HI:  rdata_d[7:0] = cmp_q[1][15:8];
                `CCT_OFF_CMP2_LO:  rdata_d[7:0] = cmp_q[1][7:0];
                default:           rdata_d = 32'h0;
            endcase
        end

        // Byte-wise count reads: latch low on first high read only
        if (psel && !pwrite && is_addr(paddr, `CCT_OFF_CNT_HI) && !lo_pend_q[0]) begin
            lo_buf_d[0]  = count_q[7:0];
            lo_pend_d[0] = 1'b1;
        end
        if (psel && !pwrite && is_addr(paddr, `CCT_OFF_SHD_HI) && !lo_pend_q[1]) begin
            lo_buf_d[1]  = count_q[7:0];
            lo_pend_d[1] = 1'b1;
        end
        if (rd && is_addr(paddr, `CCT_OFF_CNT_LO)) begin
            lo_pend_d[0] = 1'b0;
        end
        if (rd && is_addr(paddr, `CCT_OFF_SHD_LO)) begin
            lo_pend_d[1] = 1'b0;
        end

        // Status read arms the clear of flags it returned set
        if (rd && is_addr(paddr, `CCT_OFF_STATUS)) begin
            arm_d = arm_q | cct_pkg::cct_status_s'(rdata_q[7:0]);
        end
        // Shadow low byte never clears the rollover flag
        if (access && is_addr(paddr, `CCT_OFF_CNT_LO) && arm_q.rollover_flag) begin
            status_d.rollover_flag = 1'b0;
            arm_d.rollover_flag    = 1'b0;
        end
        if (tick && count_q == `CCT_CNT_WRAP) begin
            status_d.rollover_flag = 1'b1;
        end

        // Capture channels
        for (int i = 0; i < 2; i++) begin
            if (cap_hi_rd[i]) begin
                cap_lock_d[i] = 1'b1;
            end
            if (cap_lo_acc[i]) begin
                if (!pwrite) begin
                    cap_lock_d[i] = 1'b0;
                end
                if ((i == 0) ? arm_q.capture_flag1 : arm_q.capture_flag2) begin
                    if (i == 0) begin
                        status_d.capture_flag1 = 1'b0;
                        arm_d.capture_flag1    = 1'b0;
                    end else begin
                        status_d.capture_flag2 = 1'b0;
                        arm_d.capture_flag2    = 1'b0;
                    end
                end
            end
            // Pin sample plus this edge gives a flag two cycles after the pin edge
            if (cap_edge[i] && cap_en[i] && !cap_lock_q[i]) begin
                cap_d[i] = count_q;
                if (i == 0) begin
                    status_d.capture_flag1 = 1'b1;
                end else begin
                    status_d.capture_flag2 = 1'b1;
                end
            end
        end

        // Compare channels
        for (int i = 0; i < 2; i++) begin
            if (cmp_hi_wr[i]) begin
                cmp_d[i][15:8] = pwdata[7:0];
                cmp_lock_d[i]  = 1'b1;
            end
            if (cmp_lo_wr[i]) begin
                cmp_d[i][7:0] = pwdata[7:0];
                cmp_lock_d[i] = 1'b0;
            end
            if (cmp_lo_acc[i] && ((i == 0) ? arm_q.compare_flag1 : arm_q.compare_flag2)) begin
                if (i == 0) begin
                    status_d.compare_flag1 = 1'b0;
                    arm_d.compare_flag1    = 1'b0;
                end else begin
                    status_d.compare_flag2 = 1'b0;
                    arm_d.compare_flag2    = 1'b0;
                end
            end
            if (cmp_hit[i]) begin
                pin_d[i] = !compare_output_pin_oe[i] ? pin_q[i] : (i == 0) ? ctrl_one_q.compare_output_level1
                                    : ctrl_one_q.compare_output_level2;
                if (i == 0 && !ctrl_two_q.pwm_mode && !ctrl_two_q.one_pulse_mode) begin
                    status_d.compare_flag1 = 1'b1;
                end
                if (i == 1 && !ctrl_two_q.pwm_mode) begin
                    status_d.compare_flag2 = 1'b1;
                end
            end
        end

        // Control writes
        if (wr && is_addr(paddr, `CCT_OFF_CTRL_ONE)) begin
            ctrl_one_d      = pwdata[7:0];
            ctrl_one_d.rsvd = 1'b0;
            ctrl_one_d.rsvd0 = 1'b0;
        end
        if (wr && is_addr(paddr, `CCT_OFF_CTRL_TWO)) begin
            ctrl_two_d = pwdata[7:0];
        end
        status_d.rsvd = 3'h0;
        arm_d.rsvd    = 3'h0;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrl_one_q  <= '0;
            ctrl_two_q  <= '0;
            status_q    <= '0;
            count_q     <= `CCT_CNT_RESET;
            presc_q     <= 3'h0;
            ext_prev_q  <= 1'b0;
            new_count_q <= 1'b0;
            lo_buf_q[0] <= 8'h00;
            lo_buf_q[1] <= 8'h00;
            lo_pend_q   <= 2'h0;
            cap_q[0]    <= 16'h0000;
            cap_q[1]    <= 16'h0000;
            cap_prev_q  <= 4'h0;
            cap_lock_q  <= 2'h0;
            cmp_q[0]    <= `CCT_CMP_RESET;
            cmp_q[1]    <= `CCT_CMP_RESET;
            cmp_lock_q  <= 2'h0;
            pin_q       <= 2'h0;
            arm_q       <= '0;
            rdata_q     <= 32'h0;
        end else begin
            ctrl_one_q  <= ctrl_one_d;
            ctrl_two_q  <= ctrl_two_d;
            status_q    <= status_d;
            count_q     <= count_d;
            presc_q     <= presc_d;
            ext_prev_q  <= ext_prev_d;
            new_count_q <= new_count_d;
            lo_buf_q    <= lo_buf_d;
            lo_pend_q   <= lo_pend_d;
            cap_q       <= cap_d;
            cap_prev_q  <= cap_prev_d;
            cap_lock_q  <= cap_lock_d;
            cmp_q       <= cmp_d;
            cmp_lock_q  <= cmp_lock_d;
            pin_q       <= pin_d;
            arm_q       <= arm_d;
            rdata_q     <= rdata_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Pin is driven only when its output is enabled; flags still fire otherwise
    assign compare_output_pin    = pin_q;
    assign compare_output_pin_oe = {ctrl_two_q.compare_output_enable2,
                                    ctrl_two_q.compare_output_enable1};

    // Requests stay pending in the flags until mask and enable allow them
    assign timer_irq = !cpu_irq_mask &&
                       ((status_q.rollover_flag && ctrl_one_q.rollover_irq_enable) ||
                        ((status_q.capture_flag1 || status_q.capture_flag2) && ctrl_one_q.capture_irq_enable) ||
                        ((status_q.compare_flag1 || status_q.compare_flag2) && ctrl_one_q.compare_irq_enable));

endmodule // cct_timer

// File: tb/cct_pins.sv
// Partner model: drives the capture inputs and the external timer clock.
// Assumes the bench calls its tasks from one process; clk_sys comes from the bench.
`timescale 1ns/1ps
module cct_pins (
    // Clock
    input  wire logic       clk_sys,
    // Timer pins
    output logic            ext_clock_pin,
    output logic      [1:0] capture_pin
);
    // Idle levels: channel one low, channel two high
    initial begin
        ext_clock_pin = 1'b0;
        capture_pin   = 2'h2;
    end
    // Flip one capture input just after an edge
    task automatic cap_flip(input int ch);
        @(posedge clk_sys);
        capture_pin[ch] <= ~capture_pin[ch];
    endtask
    // Rising edges six cycles apart, well under a quarter of clk_sys
    task automatic ext_ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            ext_clock_pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
            ext_clock_pin <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask
endmodule // cct_pins

// File: tb/cct_timer_sva.sv
// Checker of the timer's bus, interrupt and compare pin ports.
// Assumes one clock domain; bound onto cct_timer below.
`timescale 1ns/1ps
`include "cct_cfg.svh"
module cct_timer_sva (
    // System
    input wire logic        clk_sys,
    input wire logic        nrst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [5:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // CPU and pins
    input wire logic        cpu_irq_mask,
    input wire logic        timer_irq,
    input wire logic [1:0]  compare_output_pin,
    input wire logic [1:0]  compare_output_pin_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // Bus phases; a control-two write may move the enables
    wire logic acc = psel && penable;
    wire logic setup_rd = psel && !penable && !pwrite;
    wire logic ctl2_wr = acc && pwrite && paddr == `CCT_OFF_CTRL_TWO;
    err_unmapped_a: assert property (acc && paddr > `CCT_OFF_CMP2_LO |-> pslverr)
        else $error("unmapped access without error");
    err_mapped_a: assert property (acc && paddr <= `CCT_OFF_CMP2_LO && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access flagged as error");
    err_idle_a: assert property (!acc |-> !pslverr)
        else $error("error outside access phase");
    rd_unmapped_a: assert property (setup_rd && paddr > `CCT_OFF_CMP2_LO |=> prdata == 32'h0)
        else $error("unmapped read not zero");
    rd_upper_a: assert property (prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    irq_mask_a: assert property (cpu_irq_mask |-> !timer_irq)
        else $error("interrupt while masked");
    oe_write_a: assert property (ctl2_wr |=> compare_output_pin_oe == {$past(pwdata[6]), $past(pwdata[7])})
        else $error("output enables do not follow write");
    pin_hold_a: assert property (!compare_output_pin_oe[0] && !ctl2_wr |=> $stable(compare_output_pin[0]))
        else $error("disabled compare pin moved");
    oe_read_a: assert property (setup_rd && paddr == `CCT_OFF_CTRL_TWO |=>
        {prdata[6], prdata[7]} == $past(compare_output_pin_oe))
        else $error("control two read disagrees with enables");
endmodule // cct_timer_sva
bind cct_timer cct_timer_sva u_sva (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pslverr, .cpu_irq_mask, .timer_irq, .compare_output_pin, .compare_output_pin_oe);

// File: tb/capture_compare_timer16_tb.sv
// Self-checking bench of the capture/compare timer: APB master, pin partner, expected values.
// Assumes cct_cfg.svh on the include path and the checker bound from its own file.
`timescale 1ns/1ps
`include "cct_cfg.svh"
module capture_compare_timer16_tb;
    logic        clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [5:0]  paddr = 6'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic        pready, pslverr, timer_irq, ext_clock_pin, err_q, cpu_irq_mask = 1'b1, halt_mode = 1'b0;
    logic [1:0]  capture_pin, compare_output_pin, compare_output_pin_oe;
    int          err_total = 0, checked = 0, a, v;
    // 20 MHz clock
    initial forever #25 clk_sys = ~clk_sys;
    cct_timer u_dut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cpu_irq_mask, .halt_mode, .timer_irq, .ext_clock_pin, .capture_pin, .compare_output_pin,
        .compare_output_pin_oe);
    cct_pins u_pins (.clk_sys, .ext_clock_pin, .capture_pin);
    // ****************************************************************
    // Bus and comparison tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Setup, then access held until pready is sampled high
    task automatic apb(input logic wr, input logic [5:0] ad, input logic [7:0] d);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= {24'h0, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1 && ++n < 20);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] ad, input logic [7:0] exp);
        apb(1'b0, ad, 8'h00);
        chk(rd_q, {24'h0, exp});
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        final_report;
    end
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        v = $urandom(65);
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        for (a = 0; a < 4; a++) rd(6'h2C + 6'(a * 4), a[0] ? 8'h00 : 8'h80);
        chk(32'(compare_output_pin), 32'h0);
        apb(1'b0, 6'h3C, 8'h00);
        chk({rd_q[30:0], err_q}, 32'h1);
        // Divide by eight; the low byte stays latched across repeated high reads
        apb(1'b1, `CCT_OFF_CTRL_TWO, 8'h04);
        apb(1'b1, `CCT_OFF_CNT_LO, 8'h00);
        rd(`CCT_OFF_CNT_HI, 8'hFF);
        repeat (8) @(posedge clk_sys);
        rd(`CCT_OFF_CNT_HI, 8'hFF);
        rd(`CCT_OFF_CNT_LO, 8'hFC);
        repeat (17) @(posedge clk_sys);
        rd(`CCT_OFF_CNT_LO, 8'h00);
        rd(`CCT_OFF_STATUS, 8'h20);
        apb(1'b1, `CCT_OFF_CTRL_ONE, 8'h20);
        @(negedge clk_sys);
        chk(32'(timer_irq), 32'h0);
        @(posedge clk_sys) cpu_irq_mask <= 1'b0;
        @(negedge clk_sys);
        chk(32'(timer_irq), 32'h1);
        apb(1'b0, `CCT_OFF_SHD_LO, 8'h00);
        rd(`CCT_OFF_STATUS, 8'h20);
        apb(1'b0, `CCT_OFF_CNT_LO, 8'h00);
        rd(`CCT_OFF_STATUS, 8'h00);
        // Halt right after a reload freezes the count
        apb(1'b1, `CCT_OFF_CNT_LO, 8'h00);
        halt_mode <= 1'b1;
        repeat (40) @(posedge clk_sys);
        rd(`CCT_OFF_CNT_HI, 8'hFF);
        rd(`CCT_OFF_CNT_LO, 8'hFC);
        halt_mode <= 1'b0;
        // Reads 24 cycles apart differ by 24 over the divider, whatever the phase
        for (a = 0; a < 3; a++) begin
            apb(1'b1, `CCT_OFF_CTRL_TWO, {4'h0, a[1:0], 2'h0});
            apb(1'b0, `CCT_OFF_CNT_LO, 8'h00);
            v = rd_q;
            repeat (21) @(posedge clk_sys);
            apb(1'b0, `CCT_OFF_CNT_LO, 8'h00);
            chk((rd_q - v) & 32'hFF, 32'(24 / (a == 0 ? 4 : a == 1 ? 8 : 2)));
        end
        // External clock, rising edge: five edges from FFFC give 0001
        apb(1'b1, `CCT_OFF_CTRL_TWO, 8'h0D);
        apb(1'b1, `CCT_OFF_CNT_LO, 8'h00);
        u_pins.ext_ticks(5);
        rd(`CCT_OFF_CNT_HI, 8'h00);
        rd(`CCT_OFF_CNT_LO, 8'h01);
        rd(`CCT_OFF_STATUS, 8'h20);
        // Capture per channel; a second edge after the high read is blocked
        apb(1'b1, `CCT_OFF_CTRL_ONE, 8'h82);
        for (a = 0; a < 2; a++) begin
            apb(1'b1, `CCT_OFF_CTRL_TWO, 8'h04);
            apb(1'b1, `CCT_OFF_CNT_LO, 8'h00);
            repeat (2) @(posedge clk_sys);
            u_pins.cap_flip(a);
            repeat (2) @(negedge clk_sys);
            chk(32'(timer_irq), 32'h0);
            repeat (2) @(negedge clk_sys);
            chk(32'(timer_irq), 32'h1);
            rd(`CCT_OFF_STATUS, a ? 8'h10 : 8'h80);
            rd(6'h1C + 6'(a * 8), 8'hFF);
            u_pins.cap_flip(a);
            u_pins.cap_flip(a);
            repeat (4) @(posedge clk_sys);
            rd(6'h20 + 6'(a * 8), 8'hFC);
            rd(`CCT_OFF_STATUS, 8'h00);
        end
        apb(1'b1, `CCT_OFF_CTRL_TWO, 8'h24);
        apb(1'b1, `CCT_OFF_CNT_LO, 8'h00);
        u_pins.cap_flip(0);
        u_pins.cap_flip(0);
        repeat (4) @(posedge clk_sys);
        rd(`CCT_OFF_STATUS, 8'h00);
        // Random match value; channel two suspended until its low byte arrives
        v = $urandom_range(19, 4);
        apb(1'b1, `CCT_OFF_CTRL_ONE, 8'h4C);
        apb(1'b1, `CCT_OFF_CTRL_TWO, 8'h88);
        rd(`CCT_OFF_CTRL_TWO, 8'h88);
        apb(1'b1, `CCT_OFF_CMP1_HI, 8'h00);
        apb(1'b1, `CCT_OFF_CMP1_LO, v[7:0]);
        apb(1'b1, `CCT_OFF_CMP2_HI, 8'h00);
        apb(1'b1, `CCT_OFF_CNT_LO, 8'h00);
        repeat (60) @(posedge clk_sys);
        rd(`CCT_OFF_STATUS, 8'h60);
        chk(32'(compare_output_pin), 32'h1);
        chk(32'(timer_irq), 32'h1);
        apb(1'b1, `CCT_OFF_CMP2_LO, v[7:0]);
        apb(1'b1, `CCT_OFF_CNT_LO, 8'h00);
        repeat (60) @(posedge clk_sys);
        rd(`CCT_OFF_STATUS, 8'h68);
        chk(32'(compare_output_pin), 32'h1);
        rd(`CCT_OFF_CMP1_LO, v[7:0]);
        rd(`CCT_OFF_STATUS, 8'h28);
        final_report;
    end
endmodule // capture_compare_timer16_tb
